// file: pkg/bsc_pkg.sv
// Purpose: constants and types for the buck 3/4 start-up configuration register
// Assumes: 16-bit register at one fixed address on a plain strobe port
// Notes:   voltages are carried as millivolt counts
package bsc_pkg;
    localparam logic [15:0] BSC_CFG_ADDR      = 16'h7812;
    localparam logic [15:0] BSC_CFG_RESET     = 16'h0000;
    localparam int          BSC_C4_SLOT_LSB   = 13;
    localparam int          BSC_C4_VOLT_LSB   = 8;
    localparam int          BSC_C3_SLOT_LSB   = 5;
    localparam int          BSC_C3_VOLT_LSB   = 0;
    localparam logic [6:0]  BSC_CODE_MAX      = 7'h65;
    localparam logic [11:0] BSC_BASE_MV       = 12'h352;  // 850 mV
    localparam logic [11:0] BSC_STEP_MV       = 12'h019;  // 25 mV per code
    localparam logic [11:0] BSC_SAT_MV        = 12'hD48;  // 3400 mV

    typedef enum logic [1:0] {BSC_OFF, BSC_SLOT, BSC_HWEN1, BSC_HWEN2} bsc_mode_t;

    // decoded start-up request of one converter
    typedef struct packed {
        bsc_mode_t  mode;
        logic [2:0] slot;      // timeslot 1..5, zero otherwise
        logic [6:0] code;      // full voltage code
        logic [11:0] mv;       // target voltage in millivolts
    } bsc_start_t;
endpackage

// file: rtl/bsc_startup_config.sv
// Purpose: start-up configuration register for the third and fourth buck converters
// Assumes: one clock, synchronous strobes, read data one cycle after the read strobe
// Notes:   decoded outputs are registered; they follow a write by one cycle
//
// register layout, one 16-bit word at a single address:
//   15:13  converter-4 start-up slot field
//   12:8   converter-4 start-up voltage, upper five code bits
//   7:5    converter-3 start-up slot field
//   4:0    converter-3 start-up voltage, upper five code bits
// slot field: 0 off, 1..5 timeslot, 6 hardware enable 1, 7 hardware enable 2
// voltage: 25 mV per code from 850 mV, flat at the ceiling past the top step
// the sequencer only sees the decoded structs, never the raw word
//
// Summary of operation
// - conv4 slot field bits 15:13: off, timeslots 1-5, hardware enable 1 or 2.
// - conv3 slot field bits 7:5 decoded with the same eight-value scheme.
// - conv4 voltage upper five bits in 12:8, reset zero, 100mV per count.
// - conv4 code 00h is 0.85V, 25mV per code to 65h; above saturates 3.4V.
// - conv3 voltage upper five bits in 4:0, reset zero, 100mV per count.
// - conv3 code 00h is 0.85V, 25mV per code to 65h; above saturates 3.4V.
`timescale 1ns/10ps
module bsc_startup_config
    import bsc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output bsc_start_t       conv4Start,
    output bsc_start_t       conv3Start,
    output logic [15:0]      regRdData
);
    // stored word and the decoded values that the outputs take next
    logic [15:0] startupConfig;
    bsc_start_t  next_conv4Start;
    bsc_start_t  next_conv3Start;

    // bus hits, qualified by the one mapped address
    logic        wrHit;
    logic        rdHit;

    // raw fields sliced out of the stored word
    logic [2:0]  conv4SlotField;
    logic [4:0]  conv4VoltField;
    logic [2:0]  conv3SlotField;
    logic [4:0]  conv3VoltField;

    // full voltage codes and their saturation flags
    logic [6:0]  conv4Code;
    logic [6:0]  conv3Code;
    logic        conv4Sat;
    logic        conv3Sat;

    // decoded start-up modes and timeslots
    bsc_mode_t   conv4Mode;
    bsc_mode_t   conv3Mode;
    logic [2:0]  conv4Slot;
    logic [2:0]  conv3Slot;

    // target voltages in millivolts
    logic [11:0] conv4Mv;
    logic [11:0] conv3Mv;

    // map a slot field onto the four start-up modes
    function automatic bsc_mode_t slot_mode(input logic [2:0] slotField);
        bsc_mode_t m;
        unique case (slotField)
            3'h0: begin
                m = BSC_OFF;
            end
            3'h6: begin
                m = BSC_HWEN1;
            end
            3'h7: begin
                m = BSC_HWEN2;
            end
            default: begin
                m = BSC_SLOT;
            end
        endcase
        return m;
    endfunction

    // timeslot number only for the five slot codes, zero otherwise
    function automatic logic [2:0] slot_number(input logic [2:0] slotField);
        logic [2:0] n;
        if (slotField >= 3'h1 && slotField <= 3'h5) begin
            n = slotField;
        end else begin
            n = 3'h0;
        end
        return n;
    endfunction

    // linear part of the voltage table; saturation is applied outside
    function automatic logic [11:0] code_mv(input logic [6:0] code);
        logic [11:0] mv;
        mv = BSC_BASE_MV + 12'(code * BSC_STEP_MV);
        return mv;
    endfunction

    // address match is shared by both strobes
    always_comb begin
        wrHit = regWrStrobe && (regAddr == BSC_CFG_ADDR);
        rdHit = regRdStrobe && (regAddr == BSC_CFG_ADDR);
    end

    // register storage; a write to any other address is ignored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            startupConfig <= BSC_CFG_RESET;
        end else if (wrHit) begin
            startupConfig <= regWrData;
        end
    end

    // read path: unmapped addresses return zero, data held only one cycle
    // zero rather than hold keeps a stale word off a shared read bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (rdHit) begin
            regRdData <= startupConfig;
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // field slices at their fixed positions
    always_comb begin
        conv4SlotField = startupConfig[BSC_C4_SLOT_LSB +: 3];
        conv4VoltField = startupConfig[BSC_C4_VOLT_LSB +: 5];
        conv3SlotField = startupConfig[BSC_C3_SLOT_LSB +: 3];
        conv3VoltField = startupConfig[BSC_C3_VOLT_LSB +: 5];
    end

    // only the upper code bits are stored, so the two low bits are zero
    always_comb begin
        conv4Code = {conv4VoltField, 2'h0};
        conv3Code = {conv3VoltField, 2'h0};
    end

    // codes beyond the top step pin the output at the ceiling
    always_comb begin
        conv4Sat = (conv4Code > BSC_CODE_MAX);
        conv3Sat = (conv3Code > BSC_CODE_MAX);
    end

    // start-up mode of each converter
    always_comb begin
        conv4Mode = slot_mode(conv4SlotField);
        conv3Mode = slot_mode(conv3SlotField);
    end

    // timeslot of each converter
    always_comb begin
        conv4Slot = slot_number(conv4SlotField);
        conv3Slot = slot_number(conv3SlotField);
    end

    // target voltage of converter 4
    always_comb begin
        if (conv4Sat) begin
            conv4Mv = BSC_SAT_MV;
        end else begin
            conv4Mv = code_mv(conv4Code);
        end
    end

    // target voltage of converter 3
    always_comb begin
        if (conv3Sat) begin
            conv3Mv = BSC_SAT_MV;
        end else begin
            conv3Mv = code_mv(conv3Code);
        end
    end

    // gather the decoded pieces into the carriers
    always_comb begin
        next_conv4Start      = '0;
        next_conv4Start.mode = conv4Mode;
        next_conv4Start.slot = conv4Slot;
        next_conv4Start.code = conv4Code;
        next_conv4Start.mv   = conv4Mv;
        next_conv3Start      = '0;
        next_conv3Start.mode = conv3Mode;
        next_conv3Start.slot = conv3Slot;
        next_conv3Start.code = conv3Code;
        next_conv3Start.mv   = conv3Mv;
    end

    // registered converter-4 output so the sequencer sees glitch-free settings
    // costs one cycle of latency after a write, which start-up can afford
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv4Start <= '{mode: BSC_OFF, slot: 3'h0, code: 7'h00, mv: BSC_BASE_MV};
        end else begin
            conv4Start <= next_conv4Start;
        end
    end

    // registered converter-3 output, same timing as converter 4
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv3Start <= '{mode: BSC_OFF, slot: 3'h0, code: 7'h00, mv: BSC_BASE_MV};
        end else begin
            conv3Start <= next_conv3Start;
        end
    end
endmodule

// file: testbench/bsc_startup_config_checker.sv
// Purpose: port checks of the start-up register
// Assumes: outputs follow a write by one edge
// Notes: w2/d2 delay a mapped write to when outputs show it
`timescale 1ns/10ps
module bsc_startup_config_checker import bsc_pkg::*; (
    input wire logic        ref_clk, rst, regWrStrobe, regRdStrobe,
    input wire logic [15:0] regAddr, regWrData, regRdData,
    input wire bsc_start_t  conv4Start, conv3Start);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic w1, w2;
    logic [15:0] d1, d2;
    // two stages, since register and outputs update on successive edges
    always_ff @(posedge ref_clk) {w2, w1, d2, d1} <= {w1, regWrStrobe && regAddr == BSC_CFG_ADDR, d1, regWrData};
    a_c4_slot: assert property (w2 && d2[15:13] < 3'h6 |-> conv4Start.slot == d2[15:13]) else $error("c4 slot");
    a_c3_slot: assert property (w2 && d2[7:5] < 3'h6 |-> conv3Start.slot == d2[7:5]) else $error("c3 slot");
    a_c4_code: assert property (w2 |-> conv4Start.code == {d2[12:8], 2'h0}) else $error("c4 code");
    a_c3_code: assert property (w2 |-> conv3Start.code == {d2[4:0], 2'h0}) else $error("c3 code");
    a_c4_sat: assert property (conv4Start.code > BSC_CODE_MAX |-> conv4Start.mv == BSC_SAT_MV) else $error("c4 mv");
    a_c3_sat: assert property (conv3Start.code > BSC_CODE_MAX |-> conv3Start.mv == BSC_SAT_MV) else $error("c3 mv");
    a_rd_idle: assert property (!$past(regRdStrobe) |-> regRdData == 16'h0000) else $error("stray read data");
    cover property (conv4Start.mode == BSC_HWEN2);
    cover property (conv4Start.mv == BSC_SAT_MV);
    cover property (regRdData != 16'h0000);
endmodule

// file: testbench/test_bsc_startup_config.sv
// Purpose: register access and decode tests
// Assumes: strobes set by nba just after a rising edge
// Notes: slot codes swept by one loop, both converters at once
`timescale 1ns/10ps
module test_bsc_startup_config import bsc_pkg::*; ;
    logic ref_clk = 0, rst = 1, ws = 0, rs = 0;
    logic [15:0] a = 0, wd = 0, v, rd;
    bsc_start_t c4, c3;
    int bad_count = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    bsc_startup_config u_dut(.ref_clk, .rst, .regAddr(a), .regWrData(wd), .regWrStrobe(ws),
        .regRdStrobe(rs), .conv4Start(c4), .conv3Start(c3), .regRdData(rd));
    function automatic bsc_mode_t md(int k); return k == 0 ? BSC_OFF : k < 6 ? BSC_SLOT : k == 6 ? BSC_HWEN1 : BSC_HWEN2; endfunction
    task chk(input string nm, input logic [15:0] s, e); n_compared++;
        if (s !== e) begin bad_count++; $display("wrong value %s exp %h seen %h", nm, e, s); end endtask
    // one access; read data are looked at just after the answer edge
    task acc(input logic w, input logic [15:0] ad, d); @(posedge ref_clk); ws <= w; rs <= !w; a <= ad; wd <= d;
        @(posedge ref_clk); ws <= 0; rs <= 0; #1; endtask
    task report_and_stop; $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish; endtask
    initial begin #20000; bad_count++; report_and_stop; end
    initial begin
        repeat (12) @(posedge ref_clk); rst <= 0;
        acc(0, BSC_CFG_ADDR, 0); chk("reset", rd, BSC_CFG_RESET);
        for (int i = 0; i < 8; i++) begin
            v = {3'(i), 5'h18 + 5'(i), 3'(7 - i), 5'(i)};
            acc(1, BSC_CFG_ADDR, v); acc(0, BSC_CFG_ADDR, 0); chk("readback", rd, v);
            chk("c4 mode", 16'(c4.mode), 16'(md(i)));
            chk("c3 mode", 16'(c3.mode), 16'(md(7 - i)));
            chk("c4 mv", 16'(c4.mv), i < 2 ? 16'(BSC_BASE_MV) + 16'h0064 * 16'(24 + i) : 16'(BSC_SAT_MV));
            chk("c3 mv", 16'(c3.mv), 16'(BSC_BASE_MV) + 16'h0064 * 16'(i));
        end
        acc(1, 16'h7813, 16'hFFFF); acc(0, 16'h7813, 0); chk("unmapped", rd, 16'h0000);
        acc(0, BSC_CFG_ADDR, 0); chk("kept", rd, v);
        report_and_stop;
    end
endmodule
bind bsc_startup_config bsc_startup_config_checker u_chk(.ref_clk, .rst, .regAddr, .regWrData, .regWrStrobe,
    .regRdStrobe, .conv4Start, .conv3Start, .regRdData);
